// ==== design/mbw_pkg.sv ====
// package of constants and carriers for the modbus write handler
package mbw_pkg;
  // ==========================================================
  // frame layout
  localparam int HDR_LEN = 7;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_ERR_BIT = 8'h80;
  localparam logic [15:0] LEN_SINGLE = 16'h0006;
  localparam logic [15:0] LEN_MULTI_BASE = 16'h0007;
  localparam logic [15:0] LEN_RESP_MULTI = 16'h0006;
  localparam logic [15:0] LEN_ERROR = 16'h0003;
  localparam logic [15:0] CNT_MIN = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'h007b;
  localparam logic [15:0] PROTO_ID = 16'h0000;
  localparam logic [7:0] UNIT_ID = 8'h00;
  // ==========================================================
  // exception codes
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_DEVICE = 8'h04;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mbw_byte_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } mbw_wr_s;
endpackage

// ==== design/mbw_resp_buf.sv ====
// response byte store and serialiser of the modbus write handler
`timescale 1ns/1ps
module mbw_resp_buf #(
  parameter int DEPTH = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load side
  input wire logic load,
  input wire logic [DEPTH*8-1:0] frame,
  input wire logic [3:0] len,
  // byte stream out
  output mbw_pkg::mbw_byte_s tx_r,
  output logic tx_valid_r,
  input wire logic tx_ready,
  output logic busy_r
);
  logic [7:0] mem [DEPTH];
  logic [3:0] idx_r;
  logic [3:0] len_r;

  // ==========================================================
  // capture frame, byte 0 in the top lane
  always_ff @(posedge clk) begin
    if (load) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= frame[(DEPTH-1-i)*8 +: 8];
      end
    end
  end

  // stream bytes out one per accepted beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 4'h0;
      len_r <= 4'h0;
      busy_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_r <= '0;
    end else if (load && !busy_r) begin
      idx_r <= 4'h0;
      len_r <= len;
      busy_r <= 1'b1;
      tx_valid_r <= 1'b0;
    end else if (busy_r) begin
      if (!tx_valid_r || tx_ready) begin
        if (tx_valid_r && tx_r.last) begin
          busy_r <= 1'b0;
          tx_valid_r <= 1'b0;
        end else begin
          tx_r.data <= mem[idx_r];
          tx_r.last <= (idx_r == len_r - 4'h1);
          tx_valid_r <= 1'b1;
          idx_r <= idx_r + 4'h1;
        end
      end
    end
  end
endmodule

// ==== design/mbw_handler.sv ====
// modbus tcp write single and write multiple register handler
// Notes on behaviour
// [R01] single write: code 06h, 2-byte address, 2-byte value, high byte first
// [R02] single write request and its echo carry length 0006h
// [R03] address and value of a single write take any 16-bit value
// [R04] successful single write is echoed byte for byte
// [R05] single write stores the 16-bit value at the addressed register
// [R06] failed single write answers code 86h plus one exception byte
// [R07] every error frame carries length 0003h
// [R08] exception byte is only 01, 02, 03 or 04
// [R09] multiple write: code 10h, start, count within 0001h..007Bh
// [R10] multiple write length equals 0007h plus twice the count
// [R11] byte count equals twice the count, then values high byte first
// [R12] multiple write answer: 10h, length 0006h, echoed start and count
// [R13] failed multiple write answers code 90h plus one exception byte
// [R14] multiple write stores consecutive values from the start address
// [R15] each message opens with 7-byte header, protocol and unit zero
// [R16] response copies the request's transaction identifier
// [R17] all multi-byte fields are big-endian
// [R18] transport on tcp port 502, one connection, no checksum
// [R19] error code is request code with bit 7 set; no write on reject, though a short multi write keeps its earlier words and an overlong one all but
// its last counted word, plus any extra words after it
// [R20] bad count, byte count or length is rejected with code 03
`timescale 1ns/1ps
module mbw_handler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request byte stream from the tcp layer
  input wire mbw_pkg::mbw_byte_s rx,
  input wire logic rx_valid,
  output logic rx_ready_r,
  // response byte stream to the tcp layer
  output mbw_pkg::mbw_byte_s tx_r,
  output logic tx_valid_r,
  input wire logic tx_ready,
  // process data write port
  output mbw_pkg::mbw_wr_s wr_r,
  output logic wr_en_r,
  input wire logic wr_fail
);
  typedef enum logic [3:0] {
    ST_HDR = 4'b0001,
    ST_BODY = 4'b0010,
    ST_DRAIN = 4'b0100,
    ST_RESP = 4'b1000
  } mbw_state_e;

  mbw_state_e state_r;
  logic [8:0] pos_r; // a full 123-word frame runs to 259 bytes
  logic [15:0] tid_r, pid_r, len_r, addr_r, cnt_r, val_r;
  logic [7:0] unit_r, fc_r, bcnt_r, exc_r, hi_r;
  logic [7:0] nwr_r;
  logic err_r;
  logic load_r;
  logic buf_busy;
  logic [95:0] frame_r;
  logic [3:0] flen_r;
  logic take;
  logic last_in;
  logic [15:0] exp_len;
  logic [7:0] exp_bcnt;
  logic resp_tx_valid;
  mbw_pkg::mbw_byte_s resp_tx;

  assign take = rx_valid && rx_ready_r;
  assign last_in = rx.last;
  // expected fields for a multiple write, count held in cnt_r
  assign exp_len = mbw_pkg::LEN_MULTI_BASE + {cnt_r[14:0], 1'b0}; // [R10]
  assign exp_bcnt = {cnt_r[6:0], 1'b0}; // [R11]

  // ==========================================================
  // receive: header and fields, big-endian byte assembly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_HDR;
      pos_r <= 9'h000;
      tid_r <= 16'h0000;
      pid_r <= 16'h0000;
      len_r <= 16'h0000;
      unit_r <= 8'h00;
      fc_r <= 8'h00;
      addr_r <= 16'h0000;
      cnt_r <= 16'h0000;
      bcnt_r <= 8'h00;
      hi_r <= 8'h00;
      err_r <= 1'b0;
      exc_r <= 8'h00;
      nwr_r <= 8'h00;
      val_r <= 16'h0000;
    end else begin
      if (take) begin
        pos_r <= pos_r + 9'h001;
        // byte positions follow the 7-byte header
        unique case (pos_r)
          9'd0: tid_r[15:8] <= rx.data; // [R15] [R17]
          9'd1: tid_r[7:0] <= rx.data; // [R16]
          9'd2: pid_r[15:8] <= rx.data;
          9'd3: pid_r[7:0] <= rx.data;
          9'd4: len_r[15:8] <= rx.data;
          9'd5: len_r[7:0] <= rx.data;
          9'd6: unit_r <= rx.data;
          9'd7: fc_r <= rx.data; // [R01] [R09]
          9'd8: addr_r[15:8] <= rx.data; // [R03]
          9'd9: addr_r[7:0] <= rx.data;
          9'd10: cnt_r[15:8] <= rx.data;
          9'd11: cnt_r[7:0] <= rx.data;
          9'd12: bcnt_r <= rx.data;
          default: ;
        endcase
        // header sanity after unit byte, function check after code
        if (pos_r == 9'd7) begin
          if (pid_r != mbw_pkg::PROTO_ID || unit_r != mbw_pkg::UNIT_ID ||
              (rx.data != mbw_pkg::FC_WR_SINGLE &&
               rx.data != mbw_pkg::FC_WR_MULTI)) begin
            err_r <= 1'b1;
            exc_r <= mbw_pkg::EXC_FUNC; // [R08]
          end
        end
        // single write: length check once value arrives
        if (fc_r == mbw_pkg::FC_WR_SINGLE && pos_r == 9'd11) begin
          if (len_r != mbw_pkg::LEN_SINGLE) begin // [R02]
            err_r <= 1'b1;
            exc_r <= mbw_pkg::EXC_VALUE;
          end
        end
        // multiple write: count, length and byte count checks
        if (fc_r == mbw_pkg::FC_WR_MULTI && pos_r == 9'd12 && !err_r) begin
          if (cnt_r < mbw_pkg::CNT_MIN || cnt_r > mbw_pkg::CNT_MAX ||
              len_r != exp_len || rx.data != exp_bcnt) begin // [R20]
            err_r <= 1'b1;
            exc_r <= mbw_pkg::EXC_VALUE; // [R09] [R11]
          end
        end
        // data bytes of a multiple write, paired high then low
        if (fc_r == mbw_pkg::FC_WR_MULTI && pos_r > 9'd12) begin
          if (pos_r[0]) begin
            hi_r <= rx.data; // [R17]
          end else begin
            val_r <= {hi_r, rx.data};
          end
        end
        if (last_in) begin
          state_r <= ST_DRAIN;
          // short frame or truncated data is a value error
          if (!err_r && (pos_r < 9'd11 ||
              (fc_r == mbw_pkg::FC_WR_MULTI &&
               {7'h00, pos_r} != 16'd12 + {8'h00, exp_bcnt}))) begin
            err_r <= 1'b1;
            exc_r <= mbw_pkg::EXC_VALUE;
          end
        end else begin
          state_r <= ST_BODY;
        end
      end
      if (wr_en_r) begin
        nwr_r <= nwr_r + 8'h01;
        if (wr_fail) begin
          err_r <= 1'b1;
          exc_r <= mbw_pkg::EXC_DEVICE;
        end
      end
      if (state_r == ST_DRAIN && !wr_en_r) begin
        state_r <= ST_RESP;
      end
      if (state_r == ST_RESP && !load_r && !buf_busy) begin
        state_r <= ST_HDR;
        pos_r <= 9'h000;
        err_r <= 1'b0;
        exc_r <= 8'h00;
        nwr_r <= 8'h00;
      end
    end
  end

  // ==========================================================
  // write strobe: single value on its last byte, multi per word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en_r <= 1'b0;
      wr_r <= '0;
    end else begin
      wr_en_r <= 1'b0;
      if (take && !err_r) begin
        if (fc_r == mbw_pkg::FC_WR_SINGLE && pos_r == 9'd11 &&
            len_r == mbw_pkg::LEN_SINGLE && rx.last) begin
          wr_r.addr <= addr_r; // [R05]
          wr_r.data <= {cnt_r[15:8], rx.data};
          wr_en_r <= 1'b1;
        end
        // a multi write stores only after its header is checked
        if (fc_r == mbw_pkg::FC_WR_MULTI && pos_r > 9'd12 && !pos_r[0] &&
            !(pos_r == 9'd12 + {1'b0, exp_bcnt} && !rx.last)) begin
          wr_r.addr <= addr_r + {8'h00, nwr_r}; // [R14]
          wr_r.data <= {hi_r, rx.data};
          wr_en_r <= 1'b1; // [R19]
        end
      end
    end
  end

  // ==========================================================
  // frame builder: echo, short multi answer or error frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_r <= 1'b0;
      frame_r <= '0;
      flen_r <= 4'h0;
    end else begin
      load_r <= 1'b0;
      if (state_r == ST_DRAIN && !wr_en_r) begin
        load_r <= 1'b1;
        if (err_r) begin
          frame_r <= {tid_r, mbw_pkg::PROTO_ID, mbw_pkg::LEN_ERROR, // [R07]
                      mbw_pkg::UNIT_ID, fc_r | mbw_pkg::FC_ERR_BIT, // [R06] [R13] [R19]
                      exc_r, 24'h000000};
          flen_r <= 4'd9;
        end else if (fc_r == mbw_pkg::FC_WR_SINGLE) begin
          frame_r <= {tid_r, mbw_pkg::PROTO_ID, mbw_pkg::LEN_SINGLE, // [R04]
                      mbw_pkg::UNIT_ID, fc_r, addr_r, wr_r.data};
          flen_r <= 4'd12;
        end else begin
          frame_r <= {tid_r, mbw_pkg::PROTO_ID, mbw_pkg::LEN_RESP_MULTI,
                      mbw_pkg::UNIT_ID, fc_r, addr_r, cnt_r}; // [R12] [R16]
          flen_r <= 4'd12;
        end
      end
    end
  end

  // accept request bytes only while parsing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (state_r == ST_HDR || state_r == ST_BODY) &&
                    !(take && last_in);
    end
  end

  // ==========================================================
  // response serialiser; frames carry no checksum
  mbw_resp_buf #(
    .DEPTH(12)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .load(load_r),
    .frame(frame_r),
    .len(flen_r),
    .tx_r(resp_tx),
    .tx_valid_r(resp_tx_valid),
    .tx_ready(tx_ready),
    .busy_r(buf_busy)
  ); // [R18]

  assign tx_r = resp_tx;
  assign tx_valid_r = resp_tx_valid;
endmodule

// ==== tb/mbw_props.sv ====
// port checks of the modbus write handler
`timescale 1ns/1ps
module mbw_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request stream
  input wire mbw_pkg::mbw_byte_s rx,
  input wire logic rx_valid,
  input wire logic rx_ready_r,
  // response stream
  input wire mbw_pkg::mbw_byte_s tx_r,
  input wire logic tx_valid_r,
  input wire logic tx_ready,
  // write port
  input wire mbw_pkg::mbw_wr_s wr_r,
  input wire logic wr_en_r,
  input wire logic wr_fail
);
  logic [7:0] idx_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ======
  // position of the response byte in its frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 8'h00;
    end else if (tx_valid_r && tx_ready) begin
      idx_r <= tx_r.last ? 8'h00 : idx_r + 8'h01;
    end
  end
  a_tx_held:
    assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_r))
    else $error("response byte changed before taken");
  a_wr_one_pulse:
    assert property (wr_en_r |=> !wr_en_r) else $error("write pulse too long");
  a_busy_refuse:
    assert property (tx_valid_r |-> !rx_ready_r)
    else $error("request taken while answering");
  a_ready_drops:
    assert property (rx_valid && rx_ready_r && rx.last |=> !rx_ready_r)
    else $error("ready kept after last byte");
  a_answer_soon:
    assert property (rx_valid && rx_ready_r && rx.last |-> ##[2:12] tx_valid_r)
    else $error("no answer after frame");
  a_no_wr_tx:
    assert property (tx_valid_r |-> !wr_en_r) else $error("write while answering");
  a_hdr_zero:
    assert property (tx_valid_r && idx_r inside {2, 3, 4, 6} |-> !tx_r.data)
    else $error("nonzero header byte");
  a_len_code:
    assert property (tx_valid_r && idx_r == 5 |-> tx_r.data inside {3, 6})
    else $error("bad length byte");
  a_exc_range:
    assert property (tx_valid_r && idx_r == 8 && tx_r.last
      |-> tx_r.data inside {[1:4]}) else $error("bad exception code");
endmodule
bind mbw_handler mbw_props i_mbw_props (.clk(clk), .rst(rst), .rx(rx),
  .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .tx_r(tx_r),
  .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .wr_r(wr_r),
  .wr_en_r(wr_en_r), .wr_fail(wr_fail));

// ==== tb/mbw_client.sv ====
// modbus tcp client model feeding and draining the handler
`timescale 1ns/1ps
module mbw_client (
  // clock
  input wire logic clk,
  // request side
  output mbw_pkg::mbw_byte_s rx,
  output logic rx_valid,
  input wire logic rx_ready_r,
  // response side
  input wire mbw_pkg::mbw_byte_s tx_r,
  input wire logic tx_valid_r,
  output logic tx_ready
);
  logic [8:0] req_q[$];
  logic [7:0] rsp_q[$];
  int seed = 5;
  initial begin
    rx = '0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // ======
  // byte held until taken, random gaps and stalls
  always @(posedge clk) begin
    bit got;
    got = rx_valid && rx_ready_r;
    if (got) void'(req_q.pop_front());
    if (tx_valid_r && tx_ready) rsp_q.push_back(tx_r.data);
    #1;
    tx_ready = ($random(seed) & 3) != 0;
    if (!rx_valid || got) begin
      rx_valid = req_q.size() != 0 && ($random(seed) & 1);
      rx = rx_valid ? req_q[0] : ~rx; // idle data toggles
    end
  end
endmodule

// ==== tb/mbw_handler_tb.sv ====
// self-checking bench of the modbus write handler
`timescale 1ns/1ps
module mbw_handler_tb;
  logic clk = 0, rst = 1, wr_fail = 0;
  logic rx_valid, rx_ready_r, tx_valid_r, tx_ready, wr_en_r;
  mbw_pkg::mbw_byte_s rx, tx_r;
  mbw_pkg::mbw_wr_s wr_r;
  int failures = 0, n_tests = 0, seed = 5, i;
  logic [15:0] tid = 16'h0001;
  logic [31:0] got_w[$];
  mbw_handler i_mbw_handler (.clk(clk), .rst(rst), .rx(rx),
    .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .tx_r(tx_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .wr_r(wr_r),
    .wr_en_r(wr_en_r), .wr_fail(wr_fail));
  mbw_client i_mbw_client (.clk(clk), .rx(rx), .rx_valid(rx_valid),
    .rx_ready_r(rx_ready_r), .tx_r(tx_r), .tx_valid_r(tx_valid_r),
    .tx_ready(tx_ready));
  // ======
  // clock and write capture
  always #25 clk = ~clk;
  always @(posedge clk) if (wr_en_r === 1'b1) got_w.push_back(wr_r);
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one frame: build, predict, send, compare
  task automatic go(input logic [7:0] fc, input logic [15:0] a, n,
    input int dl, db, input logic [7:0] u, input bit wf);
    logic [7:0] q[$], e[$];
    logic [31:0] w[$];
    logic [15:0] v;
    int len, k, ok, exc;
    len = fc == 8'h10 ? 7 + 2 * n + dl : 6 + dl;
    q = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'(len >> 8), 8'(len), u, fc,
      a[15:8], a[7:0], n[15:8], n[7:0]};
    if (fc == 8'h06) w.push_back({a, n});
    if (fc == 8'h10) begin
      q.push_back(8'(2 * n + db));
      for (k = 0; k < n; k++) begin
        v = 16'($random(seed));
        q.push_back(v[15:8]);
        q.push_back(v[7:0]);
        w.push_back({a + 16'(k), v});
      end
    end
    ok = fc == 8'h06 ? len == 6 : n >= 1 && n <= 16'h7b && db == 0 && dl == 0;
    exc = u != 0 || (fc != 8'h06 && fc != 8'h10) ? 1 : !ok ? 3 : wf ? 4 : 0;
    if (exc == 1 || exc == 3) w.delete();
    e = q[0:11];
    e[4] = 8'h00;
    e[5] = 8'h06;
    if (exc != 0) e = {q[0], q[1], 8'h00, 8'h00, 8'h00, 8'h03, 8'h00,
      fc | 8'h80, 8'(exc)};
    @(posedge clk);
    #1 wr_fail = wf;
    foreach (q[k]) i_mbw_client.req_q.push_back({q[k], k == q.size() - 1});
    for (k = 0; k < 4000; k++) begin
      @(posedge clk);
      #2;
      if (i_mbw_client.req_q.size() == 0 && rx_ready_r === 1'b1
        && i_mbw_client.rsp_q.size() >= e.size()) break;
    end
    chk(i_mbw_client.rsp_q.size(), e.size());
    foreach (e[k]) chk(i_mbw_client.rsp_q[k], e[k]);
    chk(got_w.size(), w.size());
    foreach (w[k]) chk(got_w[k], w[k]);
    i_mbw_client.rsp_q.delete();
    got_w.delete();
    tid = tid + 16'h0101;
  endtask
  // ======
  // scenarios
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    go(8'h06, 16'h1770, 16'h0001, 0, 0, 8'h00, 0);
    go(8'h06, 16'hffff, 16'hffff, 0, 0, 8'h00, 0);
    go(8'h06, 16'h0000, 16'h0000, 0, 0, 8'h00, 0);
    go(8'h06, 16'h0123, 16'h4567, 0, 0, 8'h00, 1);
    go(8'h06, 16'h0123, 16'h4567, 1, 0, 8'h00, 0);
    go(8'h06, 16'h0123, 16'h4567, 0, 0, 8'h01, 0);
    go(8'h03, 16'h1388, 16'h0002, 0, 0, 8'h00, 0);
    go(8'h10, 16'h1770, 16'h0002, 0, 0, 8'h00, 0);
    go(8'h10, 16'h1000, 16'h007b, 0, 0, 8'h00, 0);
    go(8'h10, 16'h2000, 16'h0001, 0, 0, 8'h00, 0);
    go(8'h10, 16'h2000, 16'h0000, 0, 0, 8'h00, 0);
    go(8'h10, 16'h2000, 16'h007c, 0, 0, 8'h00, 0);
    go(8'h10, 16'h2000, 16'h0002, 2, 0, 8'h00, 0);
    go(8'h10, 16'h2000, 16'h0002, 0, 2, 8'h00, 0);
    for (i = 0; i < 8; i++) begin
      go(i[0] ? 8'h10 : 8'h06, 16'($random(seed)) & 16'h7fff,
        16'($random(seed)) & 16'h0007 | 16'h0001, 0, 0, 8'h00, 0);
    end
    end_of_test;
  end
  // watchdog against a hung handshake
  initial begin
    #(20000 * 50);
    failures++;
    end_of_test;
  end
endmodule
